// [rtl/cppc_power_path.sv]
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "cppc_consts.svh"
// Function
// RL1 - debounce usb presence 62 ms both ways
// RL2 - debounce adapter sense 62 ms both ways
// RL3 - usb limit 100 mA, 500 mA, 1 A
// RL4 - adapter present: charge sys-bat, block usb-sys
// RL5 - drive adapter fet when adapter charges
// RL6 - no usb: block battery-to-usb path
// RL7 - charge sequencing runs without software
// RL8 - adapter presence only from sense input
// RL9 - play only: only ideal diode on (with charging off, a present adapter drives the fet instead, and usb adds the usb switch beside the diode)
// RL10 - usb charge: usb current_limit_state, usb charger on
// RL11 - suspend: chargers off, switch per enable
// RL12 - adapter charge: fet on, sys-bat charging
// RL13 - halt and full: chargers off, paths kept
// RL14 - software writes 11 for usb suspend
// RL15 - report 4-bit mode code
// RL16 - watchdog or supply fault enters halt (from usb or adapter charge only; play, suspend and full ignore both)
// RL17 - debounce restarts on early reversion
module cppc_power_path #(
   parameter int DEB_CYCLES = (`CPPC_DEB_MS * (`CPPC_CLK_HZ / 1000))
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // comparator and monitor pins
   input wire logic i_usb_pres,
   input wire logic i_adapter_sense_in,
   input wire logic i_supply_fault,
   input wire logic i_wdt_expired,
   input wire logic i_batt_full_cond,
   input wire logic i_batt_resume,
   // path controls
   output logic o_adapter_fet_drive,
   output logic [1:0] o_usb_sys_state,
   output logic [1:0] o_usb_bat_state,
   output logic [1:0] o_sys_bat_state,
   output logic o_ideal_diode_en,
   output logic o_usb_reverse_block,
   output logic [1:0] o_usb_limit,
   output logic [3:0] o_mode,
   output logic o_irq
);
   typedef enum logic [2:0] {
      CPPC_ST_PLAY = 3'h0,
      CPPC_ST_USB = 3'h1,
      CPPC_ST_SUSP = 3'h3,
      CPPC_ST_ADP = 3'h2,
      CPPC_ST_FULL = 3'h6,
      CPPC_ST_HALT = 3'h4
   } cppc_state_e;

   // refuse an interval that the debouncers cannot count
   if (DEB_CYCLES < 1) begin : g_bad_deb
      $error("debounce interval must be at least one cycle");
   end

   // two-stage synchronisers for pin inputs
   logic [5:0] sync1_r; // first stage, read only by second stage
   logic [5:0] sync2_r; // second stage
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
      end else begin
         // fixed pin order; bits 0 and 1 feed the debouncers
         sync1_r <= {i_batt_resume, i_batt_full_cond, i_wdt_expired, i_supply_fault,
                     i_adapter_sense_in, i_usb_pres};
         sync2_r <= sync1_r;
      end
   end

   // debounced presence, index 0 for usb and index 1 for the adapter
   logic [1:0] pres_on; // accepted levels
   logic [1:0] pres_ins; // one-cycle insertion events
   logic [1:0] pres_rem; // one-cycle removal events
   logic usb_on, usb_ins, usb_rem; // usb view of the vectors
   logic adp_on, adp_ins, adp_rem; // adapter view of the vectors
   // one debouncer per supply; the adapter is judged from its sense pin alone
   for (genvar g = 0; g < 2; g++) begin : g_deb
      // a reverting level restarts the count inside each debouncer
      cppc_debounce #(.COUNT(DEB_CYCLES)) u_deb ( // RL1 RL2 RL8
         .i_clock(i_clock),
         .i_rstn(i_rstn),
         .i_level(sync2_r[g]),
         .o_state(pres_on[g]),
         .o_rise(pres_ins[g]),
         .o_fall(pres_rem[g])
      );
   end
   // usb on index 0
   assign usb_on = pres_on[0];
   assign usb_ins = pres_ins[0];
   assign usb_rem = pres_rem[0];
   // adapter on index 1, never taken from the system rail
   assign adp_on = pres_on[1];
   assign adp_ins = pres_ins[1];
   assign adp_rem = pres_rem[1];

   // monitor levels after synchronisation
   logic fault, wdt, full_cond, resume_cond;
   assign fault = sync2_r[2];
   assign wdt = sync2_r[3];
   assign full_cond = sync2_r[4];
   assign resume_cond = sync2_r[5];

   // registers
   logic [7:0] ctrl_r; // charger_ctrl_seven / charger_ctrl_eight merged
   logic [`CPPC_IRQ_W-1:0] irq_stat_r; // sticky events
   logic [`CPPC_IRQ_W-1:0] irq_en_r; // interrupt enables
   logic restart_pulse; // one-shot restart request
   logic [1:0] devstat;
   logic chgena, susena, autostop, autores;
   assign devstat = ctrl_r[`CPPC_CTRL_DEVSTAT_LSB +: 2];
   assign chgena = ctrl_r[`CPPC_CTRL_CHGENA_BIT];
   assign susena = ctrl_r[`CPPC_CTRL_SUSENA_BIT];
   assign autostop = ctrl_r[`CPPC_CTRL_AUTOSTOP_BIT];
   assign autores = ctrl_r[`CPPC_CTRL_AUTORES_BIT];
   assign restart_pulse = i_wr && i_addr == `CPPC_REG_CTRL && i_wdata[`CPPC_CTRL_RESTART_BIT];

   // control register write; restart bit is self clearing
   // bits 7 and 6 are never stored, so they read back as zero
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         ctrl_r <= `CPPC_CTRL_RESET;
      end else if (i_wr && i_addr == `CPPC_REG_CTRL) begin
         ctrl_r <= {1'b0, 1'b0, i_wdata[5:0]};
      end
   end

   // interrupt enable register
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         irq_en_r <= '0;
      end else if (i_wr && i_addr == `CPPC_REG_IRQ_EN) begin
         irq_en_r <= i_wdata[`CPPC_IRQ_W-1:0];
      end
   end

   // mode state machine
   cppc_state_e state_r, state_nxt;
   logic halt_evt, full_evt;
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         // idle until a supply is debounced and charging is enabled
         CPPC_ST_PLAY: begin
            if (adp_on && chgena) begin
               state_nxt = CPPC_ST_ADP; // RL4 RL7
            end else if (usb_on && chgena) begin
               state_nxt = (devstat == `CPPC_DEVSTAT_SUSPEND) ? CPPC_ST_SUSP : CPPC_ST_USB;
            end
         end
         // charging: leave on removal, fault, full with autostop armed or change of supply
         CPPC_ST_USB, CPPC_ST_ADP: begin
            if (!chgena || (!adp_on && !usb_on)) begin
               state_nxt = CPPC_ST_PLAY;
            end else if (fault || wdt) begin
               state_nxt = CPPC_ST_HALT; // RL16
            end else if (full_cond && autostop) begin
               state_nxt = CPPC_ST_FULL; // RL7
            end else if (state_r == CPPC_ST_USB && adp_on) begin
               state_nxt = CPPC_ST_ADP; // RL4
            end else if (state_r == CPPC_ST_USB && devstat == `CPPC_DEVSTAT_SUSPEND) begin
               state_nxt = CPPC_ST_SUSP; // RL14
            end else if (state_r == CPPC_ST_ADP && !adp_on) begin
               state_nxt = CPPC_ST_PLAY;
            end
         end
         // suspend lasts while usb alone is present, charging is enabled and the field holds suspend
         CPPC_ST_SUSP: begin
            if (adp_on || !usb_on || devstat != `CPPC_DEVSTAT_SUSPEND || !chgena) begin
               state_nxt = CPPC_ST_PLAY;
            end
         end
         // full waits for removal, an armed resume or charging disabled
         CPPC_ST_FULL: begin
            if ((!adp_on && !usb_on) || (resume_cond && autores) || !chgena) begin
               state_nxt = CPPC_ST_PLAY;
            end
         end
         // halt waits for removal, a restart write or an armed resume
         CPPC_ST_HALT: begin
            if ((!adp_on && !usb_on) || restart_pulse || (resume_cond && autores)) begin
               state_nxt = CPPC_ST_PLAY;
            end
         end
         // unused codes fall back to idle
         default: state_nxt = CPPC_ST_PLAY;
      endcase
   end
   // one-cycle events on entry to halt and to full
   assign halt_evt = state_nxt == CPPC_ST_HALT && state_r != CPPC_ST_HALT;
   assign full_evt = state_nxt == CPPC_ST_FULL && state_r != CPPC_ST_FULL;

   // state register
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         state_r <= CPPC_ST_PLAY;
      end else begin
         state_r <= state_nxt;
      end
   end

   // sticky interrupt status, set beats clear
   logic [`CPPC_IRQ_W-1:0] ev_set;
   logic [`CPPC_IRQ_W-1:0] ev_clr;
   // event order matches the status bit positions
   assign ev_set = {full_evt, halt_evt, adp_rem, adp_ins, usb_rem, usb_ins};
   assign ev_clr = (i_wr && i_addr == `CPPC_REG_IRQ_CLR) ? i_wdata[`CPPC_IRQ_W-1:0] : '0;
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~ev_clr) | ev_set; // RL1 RL2 RL16
      end
   end

   // path decode from mode and presence
   logic fet_nxt, diode_nxt;
   logic [1:0] usys_nxt, ubat_nxt, sbat_nxt;
   logic [3:0] mode_nxt;
   always_comb begin
      fet_nxt = 1'b0;
      diode_nxt = 1'b0;
      usys_nxt = cppc_pkg::CPPC_OFF;
      ubat_nxt = cppc_pkg::CPPC_OFF;
      sbat_nxt = cppc_pkg::CPPC_OFF;
      mode_nxt = `CPPC_MODE_PLAY;
      unique case (state_nxt)
         // play only: battery feeds the system through the diode unless a present adapter drives the fet
         CPPC_ST_PLAY: begin
            diode_nxt = 1'b1; // RL9
            // usb may still feed the system with charging disabled
            if (adp_on) begin
               fet_nxt = 1'b1;
               diode_nxt = 1'b0;
            end else if (usb_on) begin
               usys_nxt = cppc_pkg::CPPC_CURRENT_LIMIT_STATE;
            end
         end
         // usb charge and play
         CPPC_ST_USB: begin
            usys_nxt = cppc_pkg::CPPC_CURRENT_LIMIT_STATE; // RL10
            ubat_nxt = cppc_pkg::CPPC_CHG; // RL10
            mode_nxt = `CPPC_MODE_USB_CHG;
         end
         // suspend: usb switch fully on or the diode, never both
         CPPC_ST_SUSP: begin
            usys_nxt = susena ? cppc_pkg::CPPC_ON : cppc_pkg::CPPC_OFF; // RL11
            diode_nxt = ~susena; // RL11
            mode_nxt = `CPPC_MODE_USB_SUSP;
         end
         // adapter charge and play
         CPPC_ST_ADP: begin
            fet_nxt = 1'b1; // RL5 RL12
            sbat_nxt = cppc_pkg::CPPC_CHG; // RL4 RL12
            mode_nxt = `CPPC_MODE_ADP_CHG;
         end
         // chargers stopped, supply paths kept as the present supply allows
         CPPC_ST_FULL, CPPC_ST_HALT: begin
            if (adp_on) begin
               fet_nxt = 1'b1; // RL5 RL13
            end else if (usb_on) begin
               usys_nxt = cppc_pkg::CPPC_CURRENT_LIMIT_STATE; // RL13
            end else begin
               diode_nxt = 1'b1;
            end
            mode_nxt = (state_nxt == CPPC_ST_HALT) ? `CPPC_MODE_HALT : `CPPC_MODE_BATFULL; // RL15
         end
         // unused codes report play only
         default: mode_nxt = `CPPC_MODE_PLAY;
      endcase
   end

   // registered path outputs
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_adapter_fet_drive <= 1'b0;
         o_usb_sys_state <= cppc_pkg::CPPC_OFF;
         o_usb_bat_state <= cppc_pkg::CPPC_OFF;
         o_sys_bat_state <= cppc_pkg::CPPC_OFF;
         // battery keeps the system alive and the usb pin stays isolated
         o_ideal_diode_en <= 1'b1;
         o_usb_reverse_block <= 1'b1;
         o_mode <= `CPPC_MODE_PLAY;
      end else begin
         // outputs follow the next state, so they move with the state register
         o_adapter_fet_drive <= fet_nxt;
         o_usb_sys_state <= usys_nxt;
         o_usb_bat_state <= ubat_nxt;
         o_sys_bat_state <= sbat_nxt;
         o_ideal_diode_en <= diode_nxt;
         o_usb_reverse_block <= ~usb_on; // RL6
         o_mode <= mode_nxt; // RL15
      end
   end

   // usb current limit from device-state field
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_usb_limit <= cppc_pkg::CPPC_LIM_100MA;
      end else begin
         o_usb_limit <= devstat; // RL3
      end
   end

   // interrupt output
   // uses the next status so a clear and the line drop in the same cycle
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(((irq_stat_r & ~ev_clr) | ev_set) & irq_en_r);
      end
   end

   // read data, one cycle after the read strobe
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         unique case (i_addr)
            // the clear register is write only and falls to the default
            `CPPC_REG_CTRL: o_rdata <= ctrl_r;
            `CPPC_REG_STAT: o_rdata <= {2'h0, adp_on & usb_on, adp_on | usb_on, o_mode};
            `CPPC_REG_IRQ_STAT: o_rdata <= {2'h0, irq_stat_r};
            `CPPC_REG_IRQ_EN: o_rdata <= {2'h0, irq_en_r};
            `CPPC_REG_PATHS: o_rdata <= {o_ideal_diode_en, o_adapter_fet_drive,
                                         o_sys_bat_state, o_usb_bat_state, o_usb_sys_state};
            default: o_rdata <= 8'h00;
         endcase
      end else begin
         // read data stand for one cycle only
         o_rdata <= 8'h00;
      end
   end
endmodule : cppc_power_path

// [rtl/cppc_consts.svh]
`ifndef CPPC_CONSTS_SVH
`define CPPC_CONSTS_SVH

// register offsets
`define CPPC_REG_CTRL 4'h0
`define CPPC_REG_STAT 4'h1
`define CPPC_REG_IRQ_STAT 4'h2
`define CPPC_REG_IRQ_CLR 4'h3
`define CPPC_REG_IRQ_EN 4'h4
`define CPPC_REG_PATHS 4'h5

// control register fields
`define CPPC_CTRL_DEVSTAT_LSB 0
`define CPPC_CTRL_CHGENA_BIT 2
`define CPPC_CTRL_SUSENA_BIT 3
`define CPPC_CTRL_AUTOSTOP_BIT 4
`define CPPC_CTRL_AUTORES_BIT 5
`define CPPC_CTRL_RESTART_BIT 6
`define CPPC_CTRL_RESET 8'h04

// interrupt bits
`define CPPC_IRQ_USBINS 0
`define CPPC_IRQ_USBREM 1
`define CPPC_IRQ_ADPINS 2
`define CPPC_IRQ_ADPREM 3
`define CPPC_IRQ_HALT 4
`define CPPC_IRQ_BATFULL 5
`define CPPC_IRQ_W 6

// mode codes
`define CPPC_MODE_PLAY 4'h0
`define CPPC_MODE_USB_CHG 4'h3
`define CPPC_MODE_USB_SUSP 4'h5
`define CPPC_MODE_ADP_CHG 4'h8
`define CPPC_MODE_BATFULL 4'ha
`define CPPC_MODE_HALT 4'hb

// usb device state field value for suspend
`define CPPC_DEVSTAT_SUSPEND 2'h3

// debounce time
`define CPPC_DEB_MS 62
`define CPPC_CLK_HZ 20000000

`endif

// [rtl/cppc_pkg.sv]
package cppc_pkg;
   // state of one power path element
   typedef enum logic [1:0] {
      CPPC_OFF = 2'h0,
      CPPC_ON = 2'h1,
      CPPC_CURRENT_LIMIT_STATE = 2'h2,
      CPPC_CHG = 2'h3
   } cppc_path_e;
   // usb current limit level
   typedef enum logic [1:0] {
      CPPC_LIM_100MA = 2'h0,
      CPPC_LIM_500MA = 2'h1,
      CPPC_LIM_1A = 2'h2,
      CPPC_LIM_SUSP = 2'h3
   } cppc_lim_e;
endpackage : cppc_pkg

// [rtl/cppc_debounce.sv]
`timescale 1ns/1ps
// debounces one raw comparator level and emits rise and fall events
module cppc_debounce #(
   parameter int COUNT = 1240000
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // synchronised raw level
   input wire logic i_level,
   // debounced result
   output logic o_state,
   output logic o_rise,
   output logic o_fall
);
   localparam int CW = $clog2(COUNT + 1);
   logic [CW-1:0] cnt_r; // cycles the level has differed from o_state

   initial begin
      if (COUNT < 1) $error("debounce count must be at least one");
   end

   // counter restarts whenever the level reverts
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         cnt_r <= '0;
      end else if (i_level == o_state) begin
         cnt_r <= '0; // RL17
      end else if (cnt_r == CW'(COUNT - 1)) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // accept the new level after the full interval
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_state <= 1'b0;
         o_rise <= 1'b0;
         o_fall <= 1'b0;
      end else begin
         o_rise <= 1'b0;
         o_fall <= 1'b0;
         if (i_level != o_state && cnt_r == CW'(COUNT - 1)) begin
            o_state <= i_level;
            o_rise <= i_level;
            o_fall <= ~i_level;
         end
      end
   end
endmodule : cppc_debounce

// [verification/cppc_supply_model.sv]
`timescale 1ns/1ps
// usb supply and adapter as seen at the charger's sense pins
module cppc_supply_model #(
   parameter int LAG = 3
) (
   // clock used only to time the slow plug-in lag
   input wire logic i_clock,
   // plug states commanded by the bench
   input wire logic i_usb_plug,
   input wire logic i_adp_plug,
   input wire logic i_slow,
   // comparator levels towards the block
   output logic o_usb_pres,
   output logic o_adapter_sense_in
);
   // contact history, so a slow plug reaches the pins late
   logic [7:0] usb_sh_r;
   logic [7:0] adp_sh_r;
   always_ff @(posedge i_clock) begin
      usb_sh_r <= {usb_sh_r[6:0], i_usb_plug};
      adp_sh_r <= {adp_sh_r[6:0], i_adp_plug};
   end
   // prompt or slow answer
   assign o_usb_pres = i_slow ? usb_sh_r[LAG] : i_usb_plug;
   // sense pin follows the adapter plug itself, never the system rail
   assign o_adapter_sense_in = i_slow ? adp_sh_r[LAG] : i_adp_plug;
endmodule : cppc_supply_model

// [verification/cppc_power_path_properties.sv]
`timescale 1ns/1ps
// ties path outputs to operating mode and presence history
module cppc_pp_checker #(
   parameter int DEB_CYCLES = 8
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // register port and pins
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_usb_pres,
   input wire logic i_adapter_sense_in,
   input wire logic i_supply_fault,
   // path controls
   input wire logic o_adapter_fet_drive,
   input wire logic [1:0] o_usb_sys_state,
   input wire logic [1:0] o_usb_bat_state,
   input wire logic [1:0] o_sys_bat_state,
   input wire logic o_ideal_diode_en,
   input wire logic o_usb_reverse_block,
   input wire logic [1:0] o_usb_limit,
   input wire logic [3:0] o_mode
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   // run lengths of raw pin levels; 32 bits outlast any run
   logic [31:0] usb_hi_r, usb_lo_r, adp_hi_r, idle_r;
   // last devstat field written
   logic [1:0] devstat_r;
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         usb_hi_r <= 32'h0;
         usb_lo_r <= 32'h0;
         adp_hi_r <= 32'h0;
         idle_r <= 32'h0;
      end else begin
         usb_hi_r <= i_usb_pres ? usb_hi_r + 32'h1 : 32'h0;
         usb_lo_r <= i_usb_pres ? 32'h0 : usb_lo_r + 32'h1;
         adp_hi_r <= i_adapter_sense_in ? adp_hi_r + 32'h1 : 32'h0;
         idle_r <= (i_usb_pres || i_adapter_sense_in) ? 32'h0 : idle_r + 32'h1;
      end
   end
   // shadow of the control field
   always_ff @(posedge i_clock) begin
      if (!i_rstn) devstat_r <= 2'h0;
      else if (i_wr && i_addr == 4'h0) devstat_r <= i_wdata[1:0];
   end
   usb_deb_a: assert property ($changed(o_mode) && o_mode == 4'h3 |-> usb_hi_r >= DEB_CYCLES)
      else $error("usb charge entered before presence settled");
   adp_deb_a: assert property ($changed(o_mode) && o_mode == 4'h8 |-> adp_hi_r >= DEB_CYCLES)
      else $error("adapter charge entered before sense settled");
   limit_sel_a: assert property (i_wr && i_addr == 4'h0 |-> ##2 o_usb_limit == devstat_r)
      else $error("usb limit does not follow control field");
   adp_paths_a: assert property (o_mode == 4'h8 |-> o_adapter_fet_drive && !o_ideal_diode_en
      && o_sys_bat_state == 2'h3 && o_usb_sys_state == 2'h0 && o_usb_bat_state == 2'h0)
      else $error("adapter charge paths wrong");
   usb_paths_a: assert property (o_mode == 4'h3 |-> !o_adapter_fet_drive
      && o_usb_sys_state == 2'h2 && o_usb_bat_state == 2'h3 && o_sys_bat_state == 2'h0)
      else $error("usb charge paths wrong");
   play_paths_a: assert property (o_mode == 4'h0 && idle_r > DEB_CYCLES + 8
      |-> !o_adapter_fet_drive && o_usb_sys_state == 2'h0 && o_usb_bat_state == 2'h0
      && o_sys_bat_state == 2'h0 && o_ideal_diode_en) else $error("play only paths wrong");
   susp_paths_a: assert property (o_mode == 4'h5 |-> !o_adapter_fet_drive
      && o_usb_bat_state == 2'h0 && o_sys_bat_state == 2'h0
      && (o_usb_sys_state == 2'h1) != o_ideal_diode_en) else $error("suspend paths wrong");
   stop_paths_a: assert property (o_mode inside {4'ha, 4'hb}
      |-> o_usb_bat_state == 2'h0 && o_sys_bat_state == 2'h0
      && o_usb_sys_state == (o_adapter_fet_drive ? 2'h0 : 2'h2))
      else $error("halt or full paths wrong");
   rev_block_a: assert property (usb_lo_r > DEB_CYCLES + 8 |-> o_usb_reverse_block)
      else $error("battery to usb path open without usb");
   fault_halt_a: assert property (o_mode == 4'h3 && i_supply_fault |-> ##[1:8] o_mode == 4'hb)
      else $error("supply fault did not halt charging");
endmodule : cppc_pp_checker

bind cppc_power_path cppc_pp_checker #(.DEB_CYCLES(DEB_CYCLES)) i_cppc_pp_checker (.*);

// [verification/cppc_power_path_tb_top.sv]
`timescale 1ns/1ps
`include "cppc_consts.svh"
// plugs supplies, injects faults and drives registers against a path model
module cppc_power_path_tb_top;
   localparam int DEB = 8;
   // design inputs
   logic i_clock = 1'b0;
   logic i_rstn = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0, i_rd = 1'b0, fault = 1'b0, wdt = 1'b0, full = 1'b0, res = 1'b0;
   // plug commands for the supply model
   logic usb_plug = 1'b0, adp_plug = 1'b0, slow = 1'b0, usb_pres, adp_sense;
   // design outputs
   logic [7:0] o_rdata;
   logic fet, diode, rblk, irq;
   logic [1:0] us, ub, sb, lim;
   logic [3:0] mode;
   int error_cnt = 0, num_checks = 0;
   integer seed = 32'hb2512413;
   bit sus;
   always #25 i_clock = ~i_clock;
   cppc_supply_model i_cppc_supply_model (.i_clock(i_clock), .i_usb_plug(usb_plug),
      .i_adp_plug(adp_plug), .i_slow(slow), .o_usb_pres(usb_pres),
      .o_adapter_sense_in(adp_sense));
   cppc_power_path #(.DEB_CYCLES(DEB)) i_cppc_power_path (.i_clock(i_clock), .i_rstn(i_rstn),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_usb_pres(usb_pres), .i_adapter_sense_in(adp_sense), .i_supply_fault(fault),
      .i_wdt_expired(wdt), .i_batt_full_cond(full), .i_batt_resume(res),
      .o_adapter_fet_drive(fet), .o_usb_sys_state(us), .o_usb_bat_state(ub),
      .o_sys_bat_state(sb), .o_ideal_diode_en(diode), .o_usb_reverse_block(rblk),
      .o_usb_limit(lim), .o_mode(mode), .o_irq(irq));
   // prints counts and verdict, then stops
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   // compares one value
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // expected {fet, usb-sys, usb-bat, sys-bat, diode} per mode
   function automatic logic [7:0] paths(input int m, input bit adp);
      case (m)
         3: return 8'b0_10_11_00_0;
         5: return {1'b0, sus ? 2'h1 : 2'h0, 4'h0, !sus};
         8: return 8'b1_00_00_11_0;
         10, 11: return adp ? 8'h80 : 8'b0_10_00_00_0;
         default: return 8'h01;
      endcase
   endfunction : paths
   // waits a bounded time for a mode, then compares mode and paths
   task automatic state(input logic [3:0] m, input bit adp);
      int n;
      n = 0;
      while (mode !== m && n < 200) begin
         @(posedge i_clock);
         n++;
      end
      @(posedge i_clock);
      #1;
      chk("mode", {4'h0, m}, {4'h0, mode});
      chk("paths", paths(m, adp), {fet, us, ub, sb, diode});
      if (n == 200) begin
         error_cnt++;
         final_report();
      end
   endtask : state
   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask : wr
   // one-cycle read, data compared in the following cycle
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      chk("rdata", e, o_rdata);
   endtask : rd
   initial begin
      repeat (16) @(posedge i_clock);
      i_rstn <= 1'b1;
      state(`CPPC_MODE_PLAY, 0);
      chk("idle", 8'h05, {lim, rblk, irq, 1'b1});
      rd(`CPPC_REG_CTRL, `CPPC_CTRL_RESET);
      rd(4'hf, 8'h00);
      // two short usb glitches, together at least as long as the interval, give no event
      repeat (2) begin
         @(posedge i_clock);
         usb_plug <= 1'b1;
         repeat (DEB / 2 + {$random(seed)} % (DEB / 2 - 1)) @(posedge i_clock);
         usb_plug <= 1'b0;
      end
      repeat (30) @(posedge i_clock);
      rd(`CPPC_REG_IRQ_STAT, 8'h00);
      // usb insert with event masked, then unmasked and cleared
      usb_plug <= 1'b1;
      state(`CPPC_MODE_USB_CHG, 0);
      rd(`CPPC_REG_IRQ_STAT, 8'h01);
      chk("block", 8'h00, {7'h00, rblk});
      chk("irq", 8'h00, {7'h00, irq});
      wr(`CPPC_REG_IRQ_EN, 8'h3f);
      rd(`CPPC_REG_IRQ_EN, 8'h3f);
      chk("irq", 8'h01, {7'h00, irq});
      wr(`CPPC_REG_IRQ_CLR, 8'h01);
      rd(`CPPC_REG_IRQ_STAT, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      // limit levels 100 mA, 500 mA and 1 A
      for (int d = 0; d < 3; d++) begin
         wr(`CPPC_REG_CTRL, 8'h04 | 8'(d));
         repeat (3) @(posedge i_clock);
         chk("limit", 8'(d), {6'h00, lim});
      end
      // suspend with supply enable random first, then inverted
      sus = 1'($random(seed));
      for (int k = 0; k < 2; k++) begin
         wr(`CPPC_REG_CTRL, {4'h0, sus, 3'h7});
         state(`CPPC_MODE_USB_SUSP, 0);
         wr(`CPPC_REG_CTRL, 8'h04);
         state(`CPPC_MODE_USB_CHG, 0);
         sus = !sus;
      end
      // supply fault, then watchdog, halts; restart resumes
      for (int k = 0; k < 2; k++) begin
         fault <= (k == 0);
         wdt <= (k == 1);
         state(`CPPC_MODE_HALT, 0);
         rd(`CPPC_REG_IRQ_STAT, 8'h10);
         fault <= 1'b0;
         wdt <= 1'b0;
         wr(`CPPC_REG_CTRL, 8'h44);
         rd(`CPPC_REG_CTRL, 8'h04);
         state(`CPPC_MODE_USB_CHG, 0);
      end
      // battery full with autostop, resume with autores
      wr(`CPPC_REG_CTRL, 8'h34);
      full <= 1'b1;
      state(`CPPC_MODE_BATFULL, 0);
      rd(`CPPC_REG_IRQ_STAT, 8'h30);
      full <= 1'b0;
      res <= 1'b1;
      state(`CPPC_MODE_USB_CHG, 0);
      res <= 1'b0;
      wr(`CPPC_REG_IRQ_CLR, 8'h30);
      wr(4'hf, 8'hff);
      rd(`CPPC_REG_CTRL, 8'h34);
      // slow adapter plug takes over from usb
      slow <= 1'b1;
      adp_plug <= 1'b1;
      state(`CPPC_MODE_ADP_CHG, 1);
      rd(`CPPC_REG_IRQ_STAT, 8'h04);
      rd(`CPPC_REG_STAT, 8'h38);
      rd(`CPPC_REG_PATHS, 8'h70);
      // both removed
      usb_plug <= 1'b0;
      adp_plug <= 1'b0;
      state(`CPPC_MODE_PLAY, 0);
      repeat (DEB + 10) @(posedge i_clock);
      chk("block", 8'h01, {7'h00, rblk});
      rd(`CPPC_REG_IRQ_STAT, 8'h0e);
      final_report();
   end
endmodule : cppc_power_path_tb_top
